/* File: core/rwc_reset_ctrl.sv */
// Reset sequencer, reset pin, clock source select and register slave of the reset/watchdog block
//
// The register addresses and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/10ps
module rwc_reset_ctrl
    import rwc_pkg::*;
#(
    parameter int WARMUP_CYCLES = RWC_WARMUP_CYCLES,
    parameter int WDT_EXP_MIN = RWC_WDT_EXP_MIN
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic clk_en,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic supply_ok,
    input wire logic stop_mode,
    input wire logic reset_pin_in,
    output logic reset_pin_out,
    output logic reset_pin_oe,
    output logic sys_reset,
    output logic vector_load,
    output logic [15:0] fetch_vector,
    output logic hf_osc_run,
    output logic ring_osc_run,
    output logic clk_sel_ring,
    output logic warmup_done,
    output logic stop_exit,
    output logic wdt_irq
);
    localparam int WW = $clog2(WARMUP_CYCLES + 1);
    localparam logic [WW-1:0] WARM_LAST = WW'(WARMUP_CYCLES - 1);

    typedef struct packed {
        rwc_seq_t seq;
        logic [2:0] hold_cnt;
        logic sys_reset;
        logic vector_load;
        logic [15:0] fetch_vector;
        logic stop_exit;
        logic osc_run;
        logic wdt_irq_en;
        logic [1:0] wdt_interval;
        logic wdt_restart;
        logic wdt_irq_flag;
        logic wdt_cause;
        logic wdt_irq;
        logic por_flag;
        logic ext_flag;
        logic pin_disable;
        logic bod_stop_dis;
        logic [1:0] clk_div;
        logic switchback;
        logic gpio_out;
        logic gpio_oe;
        logic pin_out;
        logic pin_oe;
        logic clk_sel_ring;
        logic [WW-1:0] warm_cnt;
        logic warm_done;
        logic waitreq;
        logic [31:0] readdata;
    } rwc_state_t;

    // Power-up image: the block's own reset counts as a power-on reset
    localparam rwc_state_t RWC_POR_STATE = '{
        seq: RWC_ST_HOLD, hold_cnt: RWC_RST_HOLD, sys_reset: 1'b1, vector_load: 1'b0,
        fetch_vector: RWC_RESET_VECTOR, stop_exit: 1'b0, osc_run: 1'b1, wdt_irq_en: 1'b0,
        wdt_interval: RWC_INTERVAL_RST, wdt_restart: 1'b0, wdt_irq_flag: 1'b0,
        wdt_cause: 1'b0, wdt_irq: 1'b0, por_flag: 1'b1, ext_flag: 1'b0,
        pin_disable: 1'b0, bod_stop_dis: 1'b0, clk_div: RWC_CLK_DIV_RST, switchback: 1'b0,
        gpio_out: 1'b0, gpio_oe: 1'b0, pin_out: 1'b0, pin_oe: 1'b0, clk_sel_ring: 1'b1,
        warm_cnt: '0, warm_done: 1'b0, waitreq: 1'b1, readdata: 32'h0000_0000};

    rwc_state_t s;
    rwc_state_t next_s;
    logic pin_sync;
    logic supply_low;
    logic pin_active;
    logic wr_req;
    logic rd_req;

    rwc_wdt_if wdt_bus ();

    ////////////////////////////////////////////////////////////////////////////////
    // Submodules

    rwc_sync #(.RST_VAL(1'b1)) u_pin_sync (
        .clock(clock),
        .srst(srst),
        .clk_en(clk_en),
        .din(reset_pin_in),
        .dout(pin_sync)
    );

    rwc_wdt_counter #(.EXP_MIN(WDT_EXP_MIN)) u_wdt (
        .clock(clock),
        .srst(srst),
        .clk_en(clk_en),
        .wdt(wdt_bus.cnt)
    );

    // Watchdog is held cleared for the whole reset so it restarts from zero
    assign wdt_bus.restart = s.wdt_restart | s.sys_reset;
    assign wdt_bus.interval = s.wdt_interval;
    assign wdt_bus.div_sel = s.clk_div;

    ////////////////////////////////////////////////////////////////////////////////
    // Register helpers

    // Byte-lane aware update of one field bit
    function automatic logic lane_bit(input logic old, input int pos,
                                      input logic [31:0] wd, input logic [3:0] be);
        lane_bit = be[pos / 8] ? wd[pos] : old;
    endfunction

    // Write-one-to-clear, honouring the byte lane
    function automatic logic w1c_hit(input int pos, input logic [31:0] wd,
                                     input logic [3:0] be);
        w1c_hit = be[pos / 8] & wd[pos];
    endfunction

    function automatic logic [31:0] reg_read(input rwc_state_t st, input logic [3:0] addr,
                                             input logic pin_lvl, input logic stop);
        logic [31:0] r;
        r = 32'h0000_0000;
        case (addr)
            RWC_OFS_WDCTL: begin
                r[RWC_WD_IRQ_EN] = st.wdt_irq_en;
                r[RWC_WD_INTERVAL +: 2] = st.wdt_interval;
                r[RWC_WD_IRQ_FLAG] = st.wdt_irq_flag;
                r[RWC_WD_CAUSE] = st.wdt_cause;
            end
            RWC_OFS_RSTCTL: begin
                r[RWC_RC_PIN_DIS] = st.pin_disable;
                r[RWC_RC_BOD_STOP_DIS] = st.bod_stop_dis;
                r[RWC_RC_CLK_DIV +: 2] = st.clk_div;
                r[RWC_RC_SWITCHBACK] = st.switchback;
                r[RWC_RC_GPIO_OUT] = st.gpio_out;
                r[RWC_RC_GPIO_OE] = st.gpio_oe;
                r[RWC_RC_POR_FLAG] = st.por_flag;
                r[RWC_RC_EXT_FLAG] = st.ext_flag;
            end
            RWC_OFS_STAT: begin
                r[RWC_ST_RING] = st.clk_sel_ring;
                r[RWC_ST_WARM_DONE] = st.warm_done;
                r[RWC_ST_PIN_LEVEL] = pin_lvl;
                r[RWC_ST_STOP] = stop;
                r[RWC_ST_WDT_IRQ] = st.wdt_irq;
            end
            default: begin
                r = 32'h0000_0000;
            end
        endcase
        reg_read = r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Next-state logic

    // Brownout can be masked in stop mode to save the detector's current
    assign supply_low = ~supply_ok & ~(s.bod_stop_dis & stop_mode);
    // Raw low asserts at once; only the synchronised high releases
    assign pin_active = ~s.pin_disable & (~reset_pin_in | ~pin_sync);
    assign wr_req = avs_write & ~s.waitreq;
    assign rd_req = avs_read & ~avs_write;

    always_comb begin
        next_s = s;
        next_s.vector_load = 1'b0;
        next_s.stop_exit = 1'b0;
        next_s.wdt_restart = 1'b0;

        // Bus slave: one wait cycle; read data is registered as waitrequest drops, write data lands on the accepting edge
        if ((rd_req | avs_write) & s.waitreq) begin
            next_s.waitreq = 1'b0;
            next_s.readdata = rd_req ? reg_read(s, avs_address, pin_sync, stop_mode)
                                     : 32'h0000_0000;
        end else begin
            next_s.waitreq = 1'b1;
        end

        if (wr_req) begin
            case (avs_address)
                RWC_OFS_WDCTL: begin
                    next_s.wdt_irq_en = lane_bit(s.wdt_irq_en, RWC_WD_IRQ_EN,
                                                 avs_writedata, avs_byteenable);
                    next_s.wdt_interval[0] = lane_bit(s.wdt_interval[0], RWC_WD_INTERVAL,
                                                      avs_writedata, avs_byteenable);
                    next_s.wdt_interval[1] = lane_bit(s.wdt_interval[1],
                                                      RWC_WD_INTERVAL + 1,
                                                      avs_writedata, avs_byteenable);
                    next_s.wdt_restart = w1c_hit(RWC_WD_RESTART, avs_writedata,
                                                 avs_byteenable);
                    if (w1c_hit(RWC_WD_IRQ_FLAG, avs_writedata, avs_byteenable)) begin
                        next_s.wdt_irq_flag = 1'b0;
                    end
                    if (w1c_hit(RWC_WD_CAUSE, avs_writedata, avs_byteenable)) begin
                        next_s.wdt_cause = 1'b0;
                    end
                end
                RWC_OFS_RSTCTL: begin
                    next_s.pin_disable = lane_bit(s.pin_disable, RWC_RC_PIN_DIS,
                                                  avs_writedata, avs_byteenable);
                    next_s.bod_stop_dis = lane_bit(s.bod_stop_dis, RWC_RC_BOD_STOP_DIS,
                                                   avs_writedata, avs_byteenable);
                    next_s.clk_div[0] = lane_bit(s.clk_div[0], RWC_RC_CLK_DIV,
                                                 avs_writedata, avs_byteenable);
                    next_s.clk_div[1] = lane_bit(s.clk_div[1], RWC_RC_CLK_DIV + 1,
                                                 avs_writedata, avs_byteenable);
                    next_s.switchback = lane_bit(s.switchback, RWC_RC_SWITCHBACK,
                                                 avs_writedata, avs_byteenable);
                    next_s.gpio_out = lane_bit(s.gpio_out, RWC_RC_GPIO_OUT,
                                               avs_writedata, avs_byteenable);
                    next_s.gpio_oe = lane_bit(s.gpio_oe, RWC_RC_GPIO_OE,
                                              avs_writedata, avs_byteenable);
                    if (w1c_hit(RWC_RC_POR_FLAG, avs_writedata, avs_byteenable)) begin
                        next_s.por_flag = 1'b0;
                    end
                    if (w1c_hit(RWC_RC_EXT_FLAG, avs_writedata, avs_byteenable)) begin
                        next_s.ext_flag = 1'b0;
                    end
                end
                default: begin
                    next_s.wdt_restart = 1'b0;
                end
            endcase
        end

        // Crystal warmup runs from the ring oscillator; switchback only once it expires
        if (!s.warm_done) begin
            if (s.warm_cnt == WARM_LAST) begin
                next_s.warm_done = 1'b1;
            end else begin
                next_s.warm_cnt = s.warm_cnt + WW'(1);
            end
        end
        if (s.warm_done && s.switchback) begin
            next_s.clk_sel_ring = 1'b0;
        end

        // Early watchdog event; hardware set wins over a same-cycle clear
        if (wdt_bus.early) begin
            next_s.wdt_irq_flag = 1'b1;
        end
        next_s.wdt_irq = next_s.wdt_irq_flag & next_s.wdt_irq_en;

        // Pin as general-purpose output only while the reset function is off
        next_s.pin_out = next_s.gpio_out;
        next_s.pin_oe = next_s.pin_disable & next_s.gpio_oe;

        // Reset sequencer
        case (s.seq)
            RWC_ST_HOLD: begin
                next_s.sys_reset = 1'b1;
                if (s.hold_cnt != 3'h0) begin
                    next_s.hold_cnt = s.hold_cnt - 3'h1;
                end else if (!pin_active) begin
                    next_s.seq = RWC_ST_RUN;
                    next_s.sys_reset = 1'b0;
                    next_s.vector_load = 1'b1;
                    next_s.fetch_vector = RWC_RESET_VECTOR;
                end
            end
            RWC_ST_RUN: begin
                if (wdt_bus.timeout) begin
                    next_s.seq = RWC_ST_HOLD;
                    next_s.hold_cnt = RWC_RST_HOLD;
                    next_s.sys_reset = 1'b1;
                    next_s.wdt_cause = 1'b1;
                end
                if (pin_active) begin
                    next_s.seq = RWC_ST_HOLD;
                    next_s.hold_cnt = RWC_RST_HOLD;
                    next_s.sys_reset = 1'b1;
                    next_s.ext_flag = 1'b1;
                    next_s.stop_exit = stop_mode;
                    if (stop_mode) begin
                        // Crystal was halted in stop mode and must warm up again
                        next_s.clk_sel_ring = 1'b1;
                        next_s.warm_cnt = '0;
                        next_s.warm_done = 1'b0;
                    end
                end
            end
            default: begin
                next_s.seq = RWC_ST_HOLD;
                next_s.sys_reset = 1'b1;
                next_s.hold_cnt = RWC_RST_HOLD;
            end
        endcase

        // Supply reset overrides all but the bus handshake and reloads the power-up image
        if (supply_low) begin
            next_s = RWC_POR_STATE;
            next_s.waitreq = s.waitreq;
            next_s.readdata = s.readdata;
            if ((rd_req | avs_write) & s.waitreq) begin
                next_s.waitreq = 1'b0;
            end else begin
                next_s.waitreq = 1'b1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            s <= RWC_POR_STATE;
        end else if (clk_en) begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign avs_readdata = s.readdata;
    assign avs_waitrequest = s.waitreq;
    assign reset_pin_out = s.pin_out;
    assign reset_pin_oe = s.pin_oe;
    assign sys_reset = s.sys_reset;
    assign vector_load = s.vector_load;
    assign fetch_vector = s.fetch_vector;
    // Oscillators are never stopped by reset; stop mode gating lives elsewhere
    assign hf_osc_run = s.osc_run;
    assign ring_osc_run = s.osc_run;
    assign clk_sel_ring = s.clk_sel_ring;
    assign warmup_done = s.warm_done;
    assign stop_exit = s.stop_exit;
    assign wdt_irq = s.wdt_irq;
endmodule // rwc_reset_ctrl

/* File: core/rwc_sync.sv */
// Two-stage level synchroniser
`timescale 1ns/10ps
module rwc_sync #(
    parameter logic RST_VAL = 1'b1
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic clk_en,
    input wire logic din,
    output logic dout
);
    typedef struct packed {
        logic s1;
        logic s2;
    } rwc_sync_t;

    rwc_sync_t s;
    rwc_sync_t next_s;

    always_comb begin
        next_s = s;
        next_s.s1 = din;
        next_s.s2 = s.s1;
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            s <= '{s1: RST_VAL, s2: RST_VAL};
        end else if (clk_en) begin
            s <= next_s;
        end
    end

    assign dout = s.s2;
endmodule // rwc_sync

/* File: core/rwc_wdt_counter.sv */
// Free-running watchdog counter with clock divide and four intervals
`timescale 1ns/10ps
module rwc_wdt_counter
    import rwc_pkg::*;
#(
    parameter int EXP_MIN = RWC_WDT_EXP_MIN,
    parameter int EXP_STEP = RWC_WDT_EXP_STEP,
    parameter int EARLY = RWC_WDT_EARLY
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic clk_en,
    rwc_wdt_if.cnt wdt
);
    localparam int CW = EXP_MIN + 3 * EXP_STEP + 1;

    typedef struct packed {
        logic [2:0] pre;
        logic [CW-1:0] count;
        logic early;
        logic timeout;
    } rwc_wdt_t;

    rwc_wdt_t s;
    rwc_wdt_t next_s;
    logic [CW-1:0] limit;
    logic [2:0] pre_max;

    always_comb begin
        limit = CW'(64'd1 << (EXP_MIN + EXP_STEP * int'(wdt.interval)));
        pre_max = 3'((4'd1 << wdt.div_sel) - 4'd1);
        next_s = s;
        next_s.early = 1'b0;
        next_s.timeout = 1'b0;
        if (wdt.restart) begin
            next_s.pre = 3'h0;
            next_s.count = '0;
        end else if (s.pre == pre_max) begin
            next_s.pre = 3'h0;
            next_s.count = s.count + CW'(1);
            if (s.count == limit - CW'(EARLY) - CW'(1)) begin
                next_s.early = 1'b1;
            end
            if (s.count == limit - CW'(1)) begin
                next_s.timeout = 1'b1;
                next_s.count = '0;
            end
        end else begin
            next_s.pre = s.pre + 3'h1;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            s <= '0;
        end else if (clk_en) begin
            s <= next_s;
        end
    end

    assign wdt.early = s.early;
    assign wdt.timeout = s.timeout;
endmodule // rwc_wdt_counter

/* File: dv/rwc_ext_src.sv */
// External reset source on the reset pin
`timescale 1ns/10ps
module rwc_ext_src (
    input wire logic pull_low,
    input wire logic pin_out,
    input wire logic pin_oe,
    output logic pin_level
);
    // Open drain with pull-up: an idle pin reads high, never a stale level
    assign pin_level = !pull_low && (pin_oe ? pin_out : 1'b1);
endmodule // rwc_ext_src

/* File: dv/rwc_sva.sv */
// Checker: timing relations at the ports of the reset controller
`timescale 1ns/10ps
module rwc_sva (
    input wire logic clock,
    input wire logic srst,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic reset_pin_in,
    input wire logic reset_pin_oe,
    input wire logic stop_mode,
    input wire logic sys_reset,
    input wire logic vector_load,
    input wire logic [15:0] fetch_vector,
    input wire logic hf_osc_run,
    input wire logic ring_osc_run,
    input wire logic clk_sel_ring,
    input wire logic warmup_done,
    input wire logic stop_exit,
    input wire logic wdt_irq
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst);
    chk_osc_run: assert property (hf_osc_run && ring_osc_run)
        else $error("oscillator stopped");
    chk_por_state: assert property ($fell(srst) |->
        sys_reset && clk_sel_ring && !warmup_done)
        else $error("bad state after power-on reset");
    chk_vec_fixed: assert property (vector_load |->
        fetch_vector == 16'h8000 && $fell(sys_reset))
        else $error("vector load wrong");
    chk_pin_hold: assert property (!reset_pin_in && !reset_pin_oe |-> ##[1:2] sys_reset)
        else $error("pin low without reset");
    chk_stop_exit: assert property (!reset_pin_in && !reset_pin_oe && stop_mode
        && !sys_reset |-> ##[1:2] stop_exit)
        else $error("stop not ended by pin reset");
    chk_ring_warm: assert property (!warmup_done |-> clk_sel_ring)
        else $error("crystal selected before warmup");
    chk_irq_lead: assert property ($rose(wdt_irq) |-> ##[510:514] $rose(sys_reset))
        else $error("watchdog irq lead wrong");
    chk_wait_one: assert property ($rose(avs_read || avs_write) |=> !avs_waitrequest)
        else $error("bus answer late");
    chk_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");
endmodule // rwc_sva

/* File: dv/tb.sv */
// Testbench: reset sources, reset pin, warmup and watchdog
`timescale 1ns/10ps
module tb;
    import rwc_pkg::*;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic [3:0] addr = 4'h0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic supply_ok = 1'b1;
    logic stop_mode = 1'b0;
    logic pull_low = 1'b0;
    logic clk_en = 1'b1;
    logic [31:0] rdata, v;
    logic [15:0] fvec;
    logic wait_req, pin_in, pin_out, pin_oe, sys_reset, vector_load, stop_exit, wdt_irq;
    logic hf_run, ring_run, ring_sel, warm_done;
    int n_errors = 0;
    int samples_checked = 0;
    int n_rst = 0;
    always #2 clock = ~clock;
    logic rst_q = 1'b1;
    always @(posedge clock) begin
        if (sys_reset === 1'b1 && rst_q === 1'b0) n_rst++;
        rst_q <= sys_reset;
    end
    rwc_ext_src i_src (.pull_low(pull_low), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_level(pin_in));
    rwc_reset_ctrl #(.WARMUP_CYCLES(64), .WDT_EXP_MIN(10)) i_dut (
        .clock(clock), .srst(srst), .clk_en(clk_en), .avs_address(addr), .avs_read(rd),
        .avs_write(wr), .avs_writedata(wdata), .avs_byteenable(4'hf), .avs_readdata(rdata),
        .avs_waitrequest(wait_req), .supply_ok(supply_ok), .stop_mode(stop_mode),
        .reset_pin_in(pin_in), .reset_pin_out(pin_out), .reset_pin_oe(pin_oe),
        .sys_reset(sys_reset), .vector_load(vector_load), .fetch_vector(fvec),
        .hf_osc_run(hf_run), .ring_osc_run(ring_run), .clk_sel_ring(ring_sel),
        .warmup_done(warm_done), .stop_exit(stop_exit), .wdt_irq(wdt_irq));
    task automatic end_sim();
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One Avalon transfer; read data lands in v
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clock);
        rd <= !w;
        wr <= w;
        addr <= a;
        wdata <= d;
        do begin
            @(posedge clock);
            k++;
        end while (wait_req !== 1'b0 && k < 50);
        v = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        check({31'h0, k < 50}, 32'h1);
    endtask
    task automatic wait_vec(output int n);
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (vector_load !== 1'b1 && n < 20000);
        check({31'h0, n < 20000}, 32'h1);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_por();
        int n;
        srst <= 1'b1;
        repeat (4) @(posedge clock);
        srst <= 1'b0;
        wait_vec(n);
        check({31'h0, n >= 4 && n <= 7}, 32'h1);
        bus(1'b0, RWC_OFS_RSTCTL, 32'h0);
        check(v, 32'h80);
        bus(1'b0, RWC_OFS_WDCTL, 32'h0);
        check(v, 32'h0);
        bus(1'b0, RWC_OFS_STAT, 32'h0);
        check(v, 32'h5);
    endtask
    task automatic t_warm();
        // Frozen clock enable must stop the warmup count short of its end
        clk_en <= 1'b0;
        repeat (80) @(posedge clock);
        check({31'h0, warm_done}, 32'h0);
        clk_en <= 1'b1;
        repeat (70) @(posedge clock);
        bus(1'b0, RWC_OFS_STAT, 32'h0);
        check(v, 32'h7);
        bus(1'b1, RWC_OFS_RSTCTL, 32'h10);
        bus(1'b0, RWC_OFS_STAT, 32'h0);
        check(v, 32'h6);
        bus(1'b0, 4'hc, 32'h0);
        check(v, 32'h0);
    endtask
    task automatic t_pin(input logic stop);
        int n, ex;
        ex = 0;
        stop_mode <= stop;
        pull_low <= 1'b1;
        repeat (8) begin
            @(posedge clock);
            ex += (stop_exit === 1'b1);
        end
        check({31'h0, sys_reset}, 32'h1);
        pull_low <= 1'b0;
        wait_vec(n);
        check(ex, stop);
        stop_mode <= 1'b0;
        bus(1'b0, RWC_OFS_RSTCTL, 32'h0);
        check(v[8], 1'b1);
        bus(1'b1, RWC_OFS_RSTCTL, 32'h100);
    endtask
    task automatic t_bod();
        int n;
        bus(1'b1, RWC_OFS_RSTCTL, 32'h2);
        stop_mode <= 1'b1;
        supply_ok <= 1'b0;
        repeat (6) @(posedge clock);
        check({31'h0, sys_reset}, 32'h0);
        stop_mode <= 1'b0;
        repeat (6) @(posedge clock);
        check({31'h0, sys_reset}, 32'h1);
        supply_ok <= 1'b1;
        wait_vec(n);
        bus(1'b0, RWC_OFS_RSTCTL, 32'h0);
        check(v, 32'h80);
    endtask
    // Early irq only with divide 1, where its lead is 512 clocks
    task automatic t_wdt(input logic [1:0] iv, input logic [1:0] dv);
        int n, m, lim;
        lim = (1 << (10 + 3 * iv)) * (1 << dv);
        m = 0;
        n = 0;
        bus(1'b1, RWC_OFS_RSTCTL, {28'h0, dv, 2'h0});
        bus(1'b1, RWC_OFS_WDCTL, {28'h0, 1'b1, iv, dv == 2'h0});
        while (sys_reset !== 1'b1 && n < 40000) begin
            @(posedge clock);
            n++;
            if (wdt_irq === 1'b1 && m == 0) m = n;
        end
        check({31'h0, n >= lim - 2 && n <= lim + 3}, 32'h1);
        if (dv == 2'h0) check({31'h0, m >= lim - 516 && m <= lim - 508}, 32'h1);
        wait_vec(n);
        bus(1'b0, RWC_OFS_WDCTL, 32'h0);
        check(v[5], 1'b1);
        bus(1'b1, RWC_OFS_WDCTL, 32'h30);
    endtask
    task automatic t_serv();
        int k;
        k = n_rst;
        bus(1'b1, RWC_OFS_RSTCTL, 32'h0);
        repeat (4) begin
            bus(1'b1, RWC_OFS_WDCTL, 32'h8);
            repeat (800) @(posedge clock);
        end
        check(n_rst - k, 0);
    endtask
    task automatic t_dis();
        bus(1'b1, RWC_OFS_WDCTL, 32'h8);
        bus(1'b1, RWC_OFS_RSTCTL, 32'h41);
        repeat (8) @(posedge clock);
        check({30'h0, pin_oe, pin_out}, 32'h2);
        check({31'h0, sys_reset}, 32'h0);
        bus(1'b1, RWC_OFS_WDCTL, 32'h16);
        bus(1'b0, RWC_OFS_WDCTL, 32'h0);
        check(v, 32'h6);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        t_por();
        t_warm();
        t_pin(1'b0);
        t_pin(1'b1);
        t_bod();
        t_wdt(2'h0, 2'h0);
        t_wdt(2'h0, 2'h1);
        t_wdt(2'h0, 2'h2);
        t_wdt(2'h0, 2'h3);
        t_wdt(2'h1, 2'h0);
        t_serv();
        t_dis();
        t_por();
        end_sim();
    end
    initial begin
        #200000;
        n_errors++;
        end_sim();
    end
endmodule // tb
bind rwc_reset_ctrl rwc_sva i_sva (.clock(clock), .srst(srst), .avs_read(avs_read),
    .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .reset_pin_in(reset_pin_in),
    .reset_pin_oe(reset_pin_oe), .stop_mode(stop_mode), .sys_reset(sys_reset),
    .vector_load(vector_load), .fetch_vector(fetch_vector), .hf_osc_run(hf_osc_run),
    .ring_osc_run(ring_osc_run), .clk_sel_ring(clk_sel_ring), .warmup_done(warmup_done),
    .stop_exit(stop_exit), .wdt_irq(wdt_irq));

/* File: include/rwc_pkg.sv */
// Package: offsets, field positions, reset values and counts of the reset/watchdog block
package rwc_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [3:0] RWC_OFS_WDCTL = 4'h0;
    localparam logic [3:0] RWC_OFS_RSTCTL = 4'h4;
    localparam logic [3:0] RWC_OFS_STAT = 4'h8;

    // watchdog_control_reg fields
    localparam int RWC_WD_IRQ_EN = 0;
    localparam int RWC_WD_INTERVAL = 1;
    localparam int RWC_WD_RESTART = 3;
    localparam int RWC_WD_IRQ_FLAG = 4;
    localparam int RWC_WD_CAUSE = 5;

    // Reset control register fields
    localparam int RWC_RC_PIN_DIS = 0;
    localparam int RWC_RC_BOD_STOP_DIS = 1;
    localparam int RWC_RC_CLK_DIV = 2;
    localparam int RWC_RC_SWITCHBACK = 4;
    localparam int RWC_RC_GPIO_OUT = 5;
    localparam int RWC_RC_GPIO_OE = 6;
    localparam int RWC_RC_POR_FLAG = 7;
    localparam int RWC_RC_EXT_FLAG = 8;

    // Status register fields
    localparam int RWC_ST_RING = 0;
    localparam int RWC_ST_WARM_DONE = 1;
    localparam int RWC_ST_PIN_LEVEL = 2;
    localparam int RWC_ST_STOP = 3;
    localparam int RWC_ST_WDT_IRQ = 4;

    ////////////////////////////////////////////////////////////////////////////////
    // Values after reset and counts
    localparam logic [15:0] RWC_RESET_VECTOR = 16'h8000;
    localparam logic [1:0] RWC_INTERVAL_RST = 2'h0;
    localparam logic [1:0] RWC_CLK_DIV_RST = 2'h0;
    localparam int RWC_WARMUP_CYCLES = 65536;
    localparam int RWC_WDT_EXP_MIN = 12;
    localparam int RWC_WDT_EXP_STEP = 3;
    localparam int RWC_WDT_EARLY = 512;
    localparam logic [2:0] RWC_RST_HOLD = 3'h4;

    typedef enum logic [1:0] {RWC_ST_HOLD, RWC_ST_RUN} rwc_seq_t;

endpackage

/* File: include/rwc_wdt_if.sv */
// Interface: control and events between the reset sequencer and the watchdog counter
`timescale 1ns/10ps
interface rwc_wdt_if;
    logic restart;
    logic [1:0] interval;
    logic [1:0] div_sel;
    logic early;
    logic timeout;

    modport ctl (output restart, output interval, output div_sel, input early, input timeout);
    modport cnt (input restart, input interval, input div_sel, output early, output timeout);
endinterface
